// ===== rtl/pwm_aux_pkg.sv
// constants shared by the modulator auxiliary block and its dead-time channels
package pwm_aux_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int CNT_W = 14;
  localparam int ACC_W = 16;
  localparam int WIN_W = 8;

  // ---------------------------------------------------------------
  // clock and capture timer
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int CAPTURE_RES_NS = 4;
  // one capture tick per clock: finest tick this clock can give
  localparam int CAPTURE_TICK_CYC = (CAPTURE_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_SAMPLE = 8'h08;
  localparam logic [7:0] OFS_EDGE0 = 8'h0c;
  localparam logic [7:0] OFS_EDGE1 = 8'h10;
  localparam logic [7:0] OFS_DETECT = 8'h14;
  localparam logic [7:0] OFS_THRESH = 8'h18;
  localparam logic [7:0] OFS_STEP = 8'h1c;
  localparam logic [7:0] OFS_MONITOR = 8'h20;
  localparam logic [7:0] OFS_MEAS = 8'h24;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;

  // ---------------------------------------------------------------
  // control field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_OS_LSB = 1;
  localparam int CTRL_DIV_LSB = 3;
  localparam int CTRL_MANUAL_BIT = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int IRQ_PERIOD_BIT = 0;
  localparam int IRQ_MEAS_LSB = 1;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [CNT_W-1:0] PERIOD_RST = 14'h3fff;
  localparam logic [CNT_W-1:0] SAMPLE_RST = 14'h0000;

  // divide setting 1..15 to divide count; setting 0 turns the interrupt off
  localparam logic [15:0][7:0] DIV_TABLE = {
    8'hff, 8'hdf, 8'hbf, 8'h9f, 8'h7f, 8'h5f, 8'h4f, 8'h3f,
    8'h2f, 8'h1f, 8'h0f, 8'h07, 8'h03, 8'h01, 8'h00, 8'h00};

endpackage

// ===== rtl/dt_link_if.sv
// signals between the block top and one dead-time channel
`timescale 1ns/1ps
interface dt_link_if;
  logic wave;
  logic sense;
  logic [pwm_aux_pkg::WIN_W-1:0] blank;
  logic [pwm_aux_pkg::WIN_W-1:0] length;
  logic [pwm_aux_pkg::WIN_W-1:0] thr_lo;
  logic [pwm_aux_pkg::WIN_W-1:0] thr_hi;
  logic [pwm_aux_pkg::WIN_W-1:0] step;
  logic manual;
  logic load;
  logic [pwm_aux_pkg::ACC_W-1:0] load_val;
  logic [pwm_aux_pkg::ACC_W-1:0] accum;
  logic [pwm_aux_pkg::WIN_W-1:0] meas;
  logic done;

  modport top (output wave, sense, blank, length, thr_lo, thr_hi, step, manual,
    load, load_val, input accum, meas, done);
  modport chan (input wave, sense, blank, length, thr_lo, thr_hi, step, manual,
    load, load_val, output accum, meas, done);
endinterface

// ===== rtl/deadtime_chan.sv
// one rectifier channel: detection window, conduction capture, edge accumulator
`timescale 1ns/1ps
module deadtime_chan (
  input wire logic clk_i,
  input wire logic rst_i,
  dt_link_if.chan lnk
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BLANK = 3'b010,
    ST_WIN = 3'b100
  } win_state_t;

  win_state_t state_reg;
  logic wave_d_reg;
  logic [pwm_aux_pkg::WIN_W-1:0] tmr_reg;
  logic [pwm_aux_pkg::WIN_W-1:0] cap_reg;
  logic [pwm_aux_pkg::WIN_W-1:0] cap_now;
  logic [pwm_aux_pkg::WIN_W-1:0] meas_reg;
  logic [pwm_aux_pkg::ACC_W-1:0] accum_reg;
  logic done_reg;
  logic fall;
  logic win_end;
  logic signed [pwm_aux_pkg::ACC_W-1:0] delta;

  assign fall = wave_d_reg & ~lnk.wave;
  assign win_end = (state_reg == ST_WIN) && (tmr_reg >= lnk.length);
  // closing window cycle still counts; saturates rather than wrapping
  assign cap_now = (lnk.sense && cap_reg != '1) ? cap_reg + 1'b1 : cap_reg;

  // falling-edge detect of the drive waveform
  always_ff @(posedge clk_i) begin
    if (rst_i) wave_d_reg <= 1'b0;
    else wave_d_reg <= lnk.wave;
  end

  // window sequencer: blank delay, then window of set length plus one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      tmr_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          tmr_reg <= '0;
          if (fall) state_reg <= (lnk.blank == '0) ? ST_WIN : ST_BLANK;
        end
        ST_BLANK: begin
          tmr_reg <= tmr_reg + 1'b1;
          if (tmr_reg + 1'b1 >= lnk.blank) begin
            state_reg <= ST_WIN;
            tmr_reg <= '0;
          end
        end
        ST_WIN: begin
          tmr_reg <= tmr_reg + 1'b1;
          if (win_end) state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // capture timer counts sense-high ticks inside the window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_reg <= '0;
      meas_reg <= '0;
    end else if (state_reg != ST_WIN) begin
      cap_reg <= '0;
    end else if (win_end) begin
      meas_reg <= cap_now;
    end else begin
      cap_reg <= cap_now;
    end
  end

  // long conduction: turn off later; short: earlier
  always_comb begin
    delta = '0;
    if (cap_now > lnk.thr_hi) delta = $signed({8'h00, lnk.step});
    else if (cap_now < lnk.thr_lo) delta = -$signed({8'h00, lnk.step});
  end

  // signed accumulator, firmware-owned in manual mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accum_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= win_end;
      if (lnk.manual) begin
        if (lnk.load) accum_reg <= lnk.load_val;
      end else if (win_end) begin
        accum_reg <= accum_reg + delta;
      end
    end
  end

  assign lnk.accum = accum_reg;
  assign lnk.meas = meas_reg;
  assign lnk.done = done_reg;

endmodule

// ===== rtl/pwm_aux.sv
// modulator auxiliaries: sample oversampling, period interrupt, rectifier dead time
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps

module pwm_aux (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] filter_adj_i,
  input wire logic diode_sense_in_0_i,
  input wire logic diode_sense_in_1_i,
  output logic rect_drive_wave_0_o,
  output logic rect_drive_wave_1_o,
  output logic error_adc_trig_o,
  output logic general_adc_trig_o,
  output logic period_irq_o,
  output logic irq_o
);

  localparam int CW = pwm_aux_pkg::CNT_W;
  localparam int AW = pwm_aux_pkg::ACC_W;
  localparam int WW = pwm_aux_pkg::WIN_W;

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic [CW-1:0] period_reg;
  logic [CW-1:0] sample_reg;
  logic [CW-1:0] rise_reg [2];
  logic [CW-1:0] fall_reg [2];
  logic [2*WW-1:0] detect_reg;
  logic [2*WW-1:0] thresh_reg;
  logic [WW-1:0] step_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  // ---------------------------------------------------------------
  // datapath state
  // ---------------------------------------------------------------
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] os_point_reg;
  logic [3:0] os_fired_reg;
  logic adc_trig_reg;
  logic [7:0] div_cnt_reg;
  logic div_pulse_reg;
  logic [AW-1:0] adj_reg [2];
  logic [1:0] wave_reg;
  logic [1:0] sense;

  // ---------------------------------------------------------------
  // decode and combinational terms
  // ---------------------------------------------------------------
  logic enable;
  logic manual;
  logic [1:0] os_sel;
  logic [3:0] div_set;
  logic [7:0] div_count;
  logic period_end;
  logic [3:0] os_total;
  logic [CW-1:0] os_step;
  logic wr_stb;
  logic rd_stb;
  logic [31:0] wmask;
  logic [31:0] rd_mux;
  logic [2:0] irq_events;
  logic [1:0] meas_done;
  logic [AW-1:0] accum [2];
  logic [WW-1:0] meas [2];

  assign enable = ctrl_reg[pwm_aux_pkg::CTRL_EN_BIT];
  assign manual = ctrl_reg[pwm_aux_pkg::CTRL_MANUAL_BIT];
  assign os_sel = ctrl_reg[pwm_aux_pkg::CTRL_OS_LSB +: 2];
  assign div_set = ctrl_reg[pwm_aux_pkg::CTRL_DIV_LSB +: 4];
  assign sense = {diode_sense_in_1_i, diode_sense_in_0_i};

  // bus strobes; ack is registered so every access takes one wait cycle
  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg;
  assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_reg;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // ---------------------------------------------------------------
  // period counter
  // ---------------------------------------------------------------
  assign period_end = enable && (cnt_reg >= period_reg);

  // free-running ramp, held at zero while disabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else if (!enable || period_end) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // error-adc sample triggers
  // ---------------------------------------------------------------
  // triggers per period: 1, 2, 4 or 8
  assign os_total = 4'h1 << os_sel;
  // spacing is sample count over factor, so the last one lands on it
  assign os_step = sample_reg >> os_sel;

  // next trigger point walks up by os_step; count limits to os_total
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      os_point_reg <= '0;
      os_fired_reg <= '0;
      adc_trig_reg <= 1'b0;
    end else if (!enable || period_end) begin
      os_point_reg <= os_step;
      os_fired_reg <= '0;
      adc_trig_reg <= 1'b0;
    end else if (cnt_reg == os_point_reg && os_fired_reg < os_total) begin
      adc_trig_reg <= 1'b1;
      os_fired_reg <= os_fired_reg + 1'b1;
      os_point_reg <= os_point_reg + os_step;
    end else begin
      adc_trig_reg <= 1'b0;
    end
  end

  assign error_adc_trig_o = adc_trig_reg;

  // ---------------------------------------------------------------
  // period interrupt divider
  // ---------------------------------------------------------------
  assign div_count = pwm_aux_pkg::DIV_TABLE[div_set];

  // count period ends; pulse once every div_count + 1 periods
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_reg <= '0;
      div_pulse_reg <= 1'b0;
    end else if (div_set == 4'h0) begin
      div_cnt_reg <= '0; // setting zero: interrupt off
      div_pulse_reg <= 1'b0;
    end else if (period_end) begin
      if (div_cnt_reg >= div_count) begin
        div_cnt_reg <= '0;
        div_pulse_reg <= 1'b1;
      end else begin
        div_cnt_reg <= div_cnt_reg + 1'b1;
        div_pulse_reg <= 1'b0;
      end
    end else begin
      div_pulse_reg <= 1'b0;
    end
  end

  assign period_irq_o = div_pulse_reg;
  assign general_adc_trig_o = div_pulse_reg;

  // ---------------------------------------------------------------
  // rectifier channels
  // ---------------------------------------------------------------
  dt_link_if dt_lnk [2] ();

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      logic signed [CW+2:0] fall_eff;

      // turn-off edge: base + filter output + applied adjustment
      always_comb begin
        fall_eff = $signed({3'b000, fall_reg[gi]})
          + $signed({filter_adj_i[AW-1], filter_adj_i})
          + $signed({adj_reg[gi][AW-1], adj_reg[gi]});
      end

      // adjustment taken at period end so the shift lands next cycle
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          adj_reg[gi] <= '0;
        end else if (period_end) begin
          adj_reg[gi] <= accum[gi];
        end
      end

      // registered drive wave: high between rise and moved fall
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          wave_reg[gi] <= 1'b0;
        end else begin
          wave_reg[gi] <= enable && (cnt_reg >= rise_reg[gi])
            && ($signed({3'b000, cnt_reg}) < fall_eff);
        end
      end

      assign dt_lnk[gi].wave = wave_reg[gi];
      assign dt_lnk[gi].sense = sense[gi];
      assign dt_lnk[gi].blank = detect_reg[WW-1:0];
      assign dt_lnk[gi].length = detect_reg[2*WW-1:WW];
      assign dt_lnk[gi].thr_lo = thresh_reg[WW-1:0];
      assign dt_lnk[gi].thr_hi = thresh_reg[2*WW-1:WW];
      assign dt_lnk[gi].step = step_reg;
      assign dt_lnk[gi].manual = manual;
      assign dt_lnk[gi].load = wr_stb && manual && wb_adr_i == pwm_aux_pkg::OFS_MONITOR;
      assign dt_lnk[gi].load_val = wb_dat_i[gi*AW +: AW];
      assign accum[gi] = dt_lnk[gi].accum;
      assign meas[gi] = dt_lnk[gi].meas;
      assign meas_done[gi] = dt_lnk[gi].done;

      deadtime_chan i_deadtime_chan (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .lnk(dt_lnk[gi])
      );
    end
  endgenerate

  assign rect_drive_wave_0_o = wave_reg[0];
  assign rect_drive_wave_1_o = wave_reg[1];

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // byte-lane masked writes, edge halves only with both lanes set; unmapped writes are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= pwm_aux_pkg::CTRL_RST;
      period_reg <= pwm_aux_pkg::PERIOD_RST;
      sample_reg <= pwm_aux_pkg::SAMPLE_RST;
      rise_reg[0] <= '0;
      rise_reg[1] <= '0;
      fall_reg[0] <= '0;
      fall_reg[1] <= '0;
      detect_reg <= '0;
      thresh_reg <= '0;
      step_reg <= '0;
      irq_mask_reg <= '0;
    end else if (wr_stb) begin
      case (wb_adr_i)
        pwm_aux_pkg::OFS_CTRL:
          ctrl_reg <= (ctrl_reg & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
        pwm_aux_pkg::OFS_PERIOD:
          period_reg <= (period_reg & ~wmask[CW-1:0]) | (wb_dat_i[CW-1:0] & wmask[CW-1:0]);
        pwm_aux_pkg::OFS_SAMPLE:
          sample_reg <= (sample_reg & ~wmask[CW-1:0]) | (wb_dat_i[CW-1:0] & wmask[CW-1:0]);
        pwm_aux_pkg::OFS_EDGE0: begin
          if (&wb_sel_i[1:0]) rise_reg[0] <= wb_dat_i[CW-1:0];
          if (&wb_sel_i[3:2]) fall_reg[0] <= wb_dat_i[16 +: CW];
        end
        pwm_aux_pkg::OFS_EDGE1: begin
          if (&wb_sel_i[1:0]) rise_reg[1] <= wb_dat_i[CW-1:0];
          if (&wb_sel_i[3:2]) fall_reg[1] <= wb_dat_i[16 +: CW];
        end
        pwm_aux_pkg::OFS_DETECT:
          detect_reg <= (detect_reg & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        pwm_aux_pkg::OFS_THRESH:
          thresh_reg <= (thresh_reg & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        pwm_aux_pkg::OFS_STEP:
          if (wb_sel_i[0]) step_reg <= wb_dat_i[WW-1:0];
        pwm_aux_pkg::OFS_IRQ_MASK:
          if (wb_sel_i[0]) irq_mask_reg <= wb_dat_i[2:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // interrupt status
  // ---------------------------------------------------------------
  assign irq_events = {meas_done, div_pulse_reg};

  // sticky bits, write one to clear; a same-cycle event wins the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= pwm_aux_pkg::IRQ_RST;
    end else if (wr_stb && wb_adr_i == pwm_aux_pkg::OFS_IRQ_STAT && wb_sel_i[0]) begin
      irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[2:0]) | irq_events;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_events;
    end
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // ---------------------------------------------------------------
  // read mux and acknowledge
  // ---------------------------------------------------------------
  // unmapped offsets read as zero and are still acknowledged
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      pwm_aux_pkg::OFS_CTRL: rd_mux[7:0] = ctrl_reg;
      pwm_aux_pkg::OFS_PERIOD: rd_mux[CW-1:0] = period_reg;
      pwm_aux_pkg::OFS_SAMPLE: rd_mux[CW-1:0] = sample_reg;
      pwm_aux_pkg::OFS_EDGE0: rd_mux = {2'b00, fall_reg[0], 2'b00, rise_reg[0]};
      pwm_aux_pkg::OFS_EDGE1: rd_mux = {2'b00, fall_reg[1], 2'b00, rise_reg[1]};
      pwm_aux_pkg::OFS_DETECT: rd_mux[15:0] = detect_reg;
      pwm_aux_pkg::OFS_THRESH: rd_mux[15:0] = thresh_reg;
      pwm_aux_pkg::OFS_STEP: rd_mux[WW-1:0] = step_reg;
      pwm_aux_pkg::OFS_MONITOR: rd_mux = {accum[1], accum[0]};
      pwm_aux_pkg::OFS_MEAS: rd_mux[15:0] = {meas[1], meas[0]};
      pwm_aux_pkg::OFS_IRQ_STAT: rd_mux[2:0] = irq_stat_reg;
      pwm_aux_pkg::OFS_IRQ_MASK: rd_mux[2:0] = irq_mask_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // one-cycle ack; data registered alongside it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
      if (rd_stb) rdata_reg <= rd_mux;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

endmodule

// ===== test/pwm_aux_assertions.sv
// port-level assertions for the modulator auxiliary block
`timescale 1ns/1ps
module pwm_aux_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rect_drive_wave_0_o,
  input wire logic rect_drive_wave_1_o,
  input wire logic error_adc_trig_o,
  input wire logic general_adc_trig_o,
  input wire logic period_irq_o,
  input wire logic irq_o
);
  // --------
  // helpers
  // --------
  logic wrote_reg;
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // idle checks hold only until software writes anything
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wrote_reg <= 1'b0;
    end else if (take && wb_we_i) begin
      wrote_reg <= 1'b1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // --------
  // properties
  // --------
  a_ack_follows_req: assert property (take |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(take))
    else $error("ack without request");
  a_adc_irq_same: assert property (period_irq_o == general_adc_trig_o)
    else $error("adc trigger differs from period interrupt");
  a_unmapped_reads_zero: assert property ((take && !wb_we_i && wb_adr_i == 8'hfc)
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_accum_start_zero: assert property ((take && !wb_we_i && !wrote_reg &&
    wb_adr_i == pwm_aux_pkg::OFS_MONITOR) |=> wb_dat_o == 32'h0)
    else $error("accumulators not zero after reset");
  a_idle_no_trigger: assert property (!wrote_reg |->
    !error_adc_trig_o && !period_irq_o && !irq_o) else $error("trigger while disabled");
  a_reset_outputs_low: assert property ($fell(rst_i) |-> !wb_ack_o &&
    !rect_drive_wave_0_o && !rect_drive_wave_1_o && !error_adc_trig_o)
    else $error("outputs not low after reset");
  c_adc_trig: cover property (error_adc_trig_o);
  c_period_irq: cover property (period_irq_o);
  c_irq_level: cover property (irq_o);
  c_wave_fall: cover property ($fell(rect_drive_wave_0_o));
endmodule

bind pwm_aux pwm_aux_assertions i_pwm_aux_assertions (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rect_drive_wave_0_o(rect_drive_wave_0_o),
  .rect_drive_wave_1_o(rect_drive_wave_1_o), .error_adc_trig_o(error_adc_trig_o),
  .general_adc_trig_o(general_adc_trig_o), .period_irq_o(period_irq_o), .irq_o(irq_o));

// ===== test/rect_driver_model.sv
// behavioural rectifier driver reporting body-diode conduction
`timescale 1ns/1ps
module rect_driver_model #(
  parameter int COND_LEN = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wave_0_i,
  input wire logic wave_1_i,
  output logic sense_0_o,
  output logic sense_1_o
);
  logic [1:0] prev_reg;
  int left_0;
  int left_1;
  // diode conducts from the cycle after the gate drops; long enough to fill the window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= 2'h0;
      left_0 <= 0;
      left_1 <= 0;
    end else begin
      prev_reg <= {wave_1_i, wave_0_i};
      left_0 <= (prev_reg[0] && !wave_0_i) ? COND_LEN : (left_0 > 0 ? left_0 - 1 : 0);
      left_1 <= (prev_reg[1] && !wave_1_i) ? COND_LEN : (left_1 > 0 ? left_1 - 1 : 0);
    end
  end
  assign sense_0_o = left_0 > 0;
  assign sense_1_o = left_1 > 0;
endmodule

// ===== test/pwm_aux_bench.sv
// self-checking bench for the modulator auxiliary block
`timescale 1ns/1ps
module pwm_aux_bench;
  logic clk_i;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [15:0] filter_adj_i = 16'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, sns_0, sns_1, wave_0, wave_1, adc_trig, gadc_trig, pirq, irq_o;
  int miscompares = 0;
  int check_count = 0;
  int trig_cnt, irq_cnt, fall_cnt, min_gap, last_trig, cyc_cnt = 0;
  logic wave_prev = 1'b0;
  int div_set[5] = '{0, 1, 2, 3, 5};
  int div_exp[5] = '{0, 32, 16, 8, 2};

  pwm_aux i_pwm_aux (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .filter_adj_i(filter_adj_i),
    .diode_sense_in_0_i(sns_0), .diode_sense_in_1_i(sns_1), .rect_drive_wave_0_o(wave_0),
    .rect_drive_wave_1_o(wave_1), .error_adc_trig_o(adc_trig),
    .general_adc_trig_o(gadc_trig), .period_irq_o(pirq), .irq_o(irq_o));
  rect_driver_model i_rect_driver_model (.clk_i(clk_i), .rst_i(rst_i), .wave_0_i(wave_0),
    .wave_1_i(wave_1), .sense_0_o(sns_0), .sense_1_o(sns_1));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // event counters; the cycle ceiling cuts a hang short
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (adc_trig === 1'b1) begin
      if (cyc_cnt - last_trig < min_gap) min_gap = cyc_cnt - last_trig;
      last_trig = cyc_cnt;
      trig_cnt++;
    end
    if (pirq === 1'b1) irq_cnt++;
    if (wave_prev === 1'b1 && wave_0 === 1'b0) fall_cnt++;
    wave_prev = wave_0;
    if (cyc_cnt > 8000) begin
      miscompares++;
      test_done();
    end
  end

  // --------
  // tasks
  // --------
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request stands until ack is sampled high at a rising edge
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb_xfer(1'b0, a, 32'h0, q);
    check(q & m, e);
  endtask

  task automatic window(input int n);
    @(negedge clk_i);
    trig_cnt = 0;
    irq_cnt = 0;
    fall_cnt = 0;
    min_gap = 1000;
    last_trig = -1000;
    repeat (n) @(negedge clk_i);
  endtask

  // --------
  // tests
  // --------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(pwm_aux_pkg::OFS_CTRL, 32'hff, 32'h0);
    rd_chk(pwm_aux_pkg::OFS_MONITOR, 32'hffffffff, 32'h0);
    wr(8'hfc, 32'hffffffff);
    rd_chk(8'hfc, 32'hffffffff, 32'h0);
    $display("test reset done");
    wr(pwm_aux_pkg::OFS_PERIOD, 32'hf);
    wr(pwm_aux_pkg::OFS_SAMPLE, 32'h8);
    for (int os = 0; os < 4; os++) begin
      // restart from disabled so the first period already uses the new spacing
      wr(pwm_aux_pkg::OFS_CTRL, 32'(2 * os));
      wr(pwm_aux_pkg::OFS_CTRL, 32'(1 + 2 * os));
      window(64);
      check(32'(trig_cnt), 32'(4 << os));
      check(32'(min_gap), (os == 0) ? 32'h10 : 32'(8 >> os));
    end
    $display("test oversampling done");
    // ascending order keeps the divider count below each new target
    for (int i = 0; i < 5; i++) begin
      wr(pwm_aux_pkg::OFS_CTRL, 32'(1 + 8 * div_set[i]));
      window(512);
      check(32'(irq_cnt), 32'(div_exp[i]));
    end
    $display("test divider done");
    wr(pwm_aux_pkg::OFS_CTRL, 32'h1);
    wr(pwm_aux_pkg::OFS_IRQ_MASK, 32'h1);
    @(negedge clk_i);
    check({31'h0, irq_o}, 32'h1);
    wr(pwm_aux_pkg::OFS_IRQ_STAT, 32'h1);
    @(negedge clk_i);
    check({31'h0, irq_o}, 32'h0);
    wr(pwm_aux_pkg::OFS_IRQ_MASK, 32'h0);
    wr(pwm_aux_pkg::OFS_CTRL, 32'h9);
    window(64);
    check({31'h0, irq_o}, 32'h0);
    rd_chk(pwm_aux_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
    $display("test interrupt done");
    wr(pwm_aux_pkg::OFS_CTRL, 32'h0);
    wr(pwm_aux_pkg::OFS_PERIOD, 32'h1f);
    wr(pwm_aux_pkg::OFS_EDGE0, 32'h00030001);
    wr(pwm_aux_pkg::OFS_EDGE1, 32'h00030001);
    wr(pwm_aux_pkg::OFS_DETECT, 32'h0301);
    wr(pwm_aux_pkg::OFS_THRESH, 32'h0201);
    wr(pwm_aux_pkg::OFS_STEP, 32'h1);
    window(1);
    wr(pwm_aux_pkg::OFS_CTRL, 32'h1);
    while (fall_cnt < 3) @(negedge clk_i);
    repeat (12) @(negedge clk_i);
    rd_chk(pwm_aux_pkg::OFS_MONITOR, 32'hffffffff, 32'h00030003);
    rd_chk(pwm_aux_pkg::OFS_MEAS, 32'hffff, 32'h0404);
    rd_chk(pwm_aux_pkg::OFS_IRQ_STAT, 32'h6, 32'h6);
    // raised thresholds: full window now counts as short, steps walk back
    wr(pwm_aux_pkg::OFS_THRESH, 32'h0605);
    window(1);
    while (fall_cnt < 3) @(negedge clk_i);
    repeat (12) @(negedge clk_i);
    rd_chk(pwm_aux_pkg::OFS_MONITOR, 32'hffffffff, 32'h0);
    wr(pwm_aux_pkg::OFS_CTRL, 32'h81);
    wr(pwm_aux_pkg::OFS_MONITOR, 32'hfffe0005);
    repeat (100) @(negedge clk_i);
    rd_chk(pwm_aux_pkg::OFS_MONITOR, 32'hffffffff, 32'hfffe0005);
    $display("test dead time done");
    test_done();
  end
endmodule
